// *** hw/pc2_pkg.sv ***
package pc2_pkg;
    localparam logic [11:0] PC2_OFF_CTRL2   = 12'h028;  // offset 0x028 is register index 0x00a times 4
    localparam logic [11:0] PC2_IDX_CTRL2   = 12'h00a;
    localparam logic [11:0] PC2_OFF_CTRL1   = 12'h024;
    localparam logic [11:0] PC2_IDX_CTRL1   = 12'h009;
    localparam logic [11:0] PC2_OFF_STATUS  = 12'h040;
    localparam logic [15:0] PC2_CTRL2_RST   = 16'h0004;
    localparam logic [15:0] PC2_CTRL2_WMASK = 16'h3fff;
    localparam logic [15:0] PC2_CTRL1_RST   = 16'h0001;
    localparam int PC2_B_FASTUP   = 6;
    localparam int PC2_B_EXTFD    = 5;
    localparam int PC2_B_ENHLED   = 4;
    localparam int PC2_B_ISOHD    = 3;
    localparam int PC2_B_IDLEERR  = 2;
    localparam int PC2_B_ODDDIS   = 1;
    localparam int PC2_B_RXCLK    = 0;
    localparam int PC2_B_MDIX_FAST   = 6;
    localparam int PC2_B_MDIX_ROBUST = 5;
    // parallel-detect link-up times
    localparam int PC2_PD_NORMAL_US = 1000;
    localparam int PC2_PD_FAST_US   = 100;
    localparam int PC2_CLK_MHZ      = 200;
    localparam int PC2_PD_NORMAL_CYC = PC2_PD_NORMAL_US * PC2_CLK_MHZ;
    localparam int PC2_PD_FAST_CYC   = PC2_PD_FAST_US * PC2_CLK_MHZ;
endpackage

// *** hw/pc2_sync.sv ***
`timescale 1ns/1ps
// two-flop level synchroniser for the rmii receive clock
module pc2_sync (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // pc2_sync

// *** hw/pc2_top.sv ***
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module pc2_top #(
    parameter int PD_NORMAL_CYC = pc2_pkg::PC2_PD_NORMAL_CYC,
    parameter int PD_FAST_CYC   = pc2_pkg::PC2_PD_FAST_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        link_up,
    input  wire logic        link_100,
    input  wire logic        partner_forced_100,
    input  wire logic        resolved_fd,
    input  wire logic        pd_start,
    output logic             pd_done,
    output logic             full_duplex,
    output logic             link_led,
    output logic             mii_isolate,
    input  wire logic        rx_idle,
    input  wire logic        rx_sym_err,
    output logic             rx_err_flag,
    input  wire logic        tx_nib_en,
    input  wire logic        tx_nib_er,
    output logic             tx_en_out,
    output logic             tx_er_out,
    input  wire logic        rmii_rx_clk,
    input  wire logic [1:0]  rmii_rxd,
    output logic [1:0]       rmii_rxd_out
);
    logic [15:0] ctrl2_r, ctrl2_nxt;
    logic [15:0] ctrl1_r, ctrl1_nxt;
    logic        pready_nxt, pslverr_nxt;
    logic [31:0] prdata_nxt;
    logic        mdix_auto;
    logic [15:0] ctrl2_eff;
    logic        acc, hit2, hit1, hits;

    assign mdix_auto = ctrl1_r[pc2_pkg::PC2_B_MDIX_FAST] | ctrl1_r[pc2_pkg::PC2_B_MDIX_ROBUST];
    always_comb begin
        ctrl2_eff = ctrl2_r;
        if (mdix_auto) begin
            ctrl2_eff[pc2_pkg::PC2_B_FASTUP] = 1'b1;
        end
    end

    // one wait state in the access phase; pready rises the cycle after the first access cycle
    assign acc  = psel & penable & ~pready;
    assign hit2 = paddr == pc2_pkg::PC2_OFF_CTRL2;
    assign hit1 = paddr == pc2_pkg::PC2_OFF_CTRL1;
    assign hits = paddr == pc2_pkg::PC2_OFF_STATUS;

    always_comb begin
        ctrl2_nxt   = ctrl2_r;
        ctrl1_nxt   = ctrl1_r;
        pready_nxt  = acc;
        pslverr_nxt = acc & ~(hit1 | hit2 | hits);
        prdata_nxt  = 32'h0000_0000;
        if (acc && pwrite && hit2) begin
            ctrl2_nxt = pwdata[15:0] & pc2_pkg::PC2_CTRL2_WMASK;
        end
        if (acc && pwrite && hit1) begin
            ctrl1_nxt = pwdata[15:0];
        end
        if (acc && !pwrite) begin
            if (hit2) begin
                prdata_nxt = {16'h0000, ctrl2_eff & pc2_pkg::PC2_CTRL2_WMASK};
            end else if (hit1) begin
                prdata_nxt = {16'h0000, ctrl1_r};
            end else if (hits) begin
                prdata_nxt = {26'h0, mii_isolate, link_led, full_duplex,
                              rx_err_flag, pd_done, tx_en_out};
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl2_r <= pc2_pkg::PC2_CTRL2_RST;
            ctrl1_r <= pc2_pkg::PC2_CTRL1_RST;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            ctrl2_r <= ctrl2_nxt;
            ctrl1_r <= ctrl1_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
            prdata  <= prdata_nxt;
        end
    end

    // parallel detection timer
    typedef enum logic [0:0] {PC2_PD_IDLE, PC2_PD_RUN} pc2_pd_t;
    pc2_pd_t     pd_st_r, pd_st_nxt;
    logic [31:0] pd_cnt_r, pd_cnt_nxt;
    logic        pd_done_nxt;

    always_comb begin
        pd_st_nxt   = pd_st_r;
        pd_cnt_nxt  = pd_cnt_r;
        pd_done_nxt = 1'b0;
        unique case (pd_st_r)
            PC2_PD_IDLE: begin
                if (pd_start) begin
                    pd_st_nxt = PC2_PD_RUN;
                    // length chosen at start; a mid-run change takes effect next time
                    pd_cnt_nxt = ctrl2_eff[pc2_pkg::PC2_B_FASTUP] ?
                                 32'(PD_FAST_CYC - 1) : 32'(PD_NORMAL_CYC - 1);
                end
            end
            PC2_PD_RUN: begin
                if (pd_cnt_r == 32'h0) begin
                    pd_st_nxt   = PC2_PD_IDLE;
                    pd_done_nxt = 1'b1;
                end else begin
                    pd_cnt_nxt = pd_cnt_r - 32'h1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pd_st_r  <= PC2_PD_IDLE;
            pd_cnt_r <= 32'h0;
            pd_done  <= 1'b0;
        end else begin
            pd_st_r  <= pd_st_nxt;
            pd_cnt_r <= pd_cnt_nxt;
            pd_done  <= pd_done_nxt;
        end
    end

    // link status outputs
    logic fd_nxt, led_nxt, iso_nxt, rxerr_nxt;
    always_comb begin
        fd_nxt = resolved_fd;
        if (ctrl2_r[pc2_pkg::PC2_B_EXTFD] && link_100 && partner_forced_100) begin
            fd_nxt = 1'b1;
        end
        if (ctrl2_r[pc2_pkg::PC2_B_ENHLED]) begin
            led_nxt = link_up & link_100 & fd_nxt;
        end else begin
            led_nxt = link_up;
        end
        iso_nxt = ctrl2_r[pc2_pkg::PC2_B_ISOHD] & link_up & link_100 & ~fd_nxt;
        rxerr_nxt = rx_sym_err & (~rx_idle | ctrl2_r[pc2_pkg::PC2_B_IDLEERR]);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            full_duplex <= 1'b0;
            link_led    <= 1'b0;
            mii_isolate <= 1'b0;
            rx_err_flag <= 1'b0;
        end else begin
            full_duplex <= fd_nxt;
            link_led    <= led_nxt;
            mii_isolate <= iso_nxt;
            rx_err_flag <= rxerr_nxt;
        end
    end

    // transmit nibble path; one core_clk cycle stands for one TX_CLK cycle
    logic odd_r, odd_nxt;
    logic txen_nxt, txer_nxt;
    always_comb begin
        txen_nxt = tx_nib_en;
        txer_nxt = tx_nib_en & tx_nib_er;
        odd_nxt  = tx_nib_en ? ~odd_r : 1'b0;
        if (!tx_nib_en && odd_r && !ctrl2_r[pc2_pkg::PC2_B_ODDDIS]) begin
            txen_nxt = 1'b1;
            txer_nxt = 1'b1;
        end
        // when disabled the drop passes straight through
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            odd_r     <= 1'b0;
            tx_en_out <= 1'b0;
            tx_er_out <= 1'b0;
        end else begin
            odd_r     <= odd_nxt;
            tx_en_out <= txen_nxt;
            tx_er_out <= txer_nxt;
        end
    end

    // rmii receive sampling: rx clock edges detected after synchronising
    logic       rxclk_s, rxclk_d_r;
    logic [1:0] rxd_nxt;
    pc2_sync u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .d        (rmii_rx_clk),
        .q        (rxclk_s)
    );
    always_comb begin
        rxd_nxt = rmii_rxd_out;
        if (ctrl2_r[pc2_pkg::PC2_B_RXCLK]) begin
            if (rxclk_s && !rxclk_d_r) begin
                rxd_nxt = rmii_rxd;
            end
        end else begin
            rxd_nxt = rmii_rxd;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rxclk_d_r    <= 1'b0;
            rmii_rxd_out <= 2'b00;
        end else begin
            rxclk_d_r    <= rxclk_s;
            rmii_rxd_out <= rxd_nxt;
        end
    end
endmodule // pc2_top

// *** testbench/pc2_mac_model.sv ***
`timescale 1ns/1ps
module pc2_mac_model (
    input  wire logic       core_clk,
    output logic            tx_nib_en,
    output logic            tx_nib_er,
    output logic            rmii_rx_clk,
    output logic [1:0]      rmii_rxd
);
    initial begin
        tx_nib_en = 1'b0;
        tx_nib_er = 1'b0;
        rmii_rx_clk = 1'b0;
        rmii_rxd = 2'h0;
    end
    task automatic send(input int n);
        repeat (n) @(posedge core_clk) tx_nib_en <= 1'b1;
        @(posedge core_clk) tx_nib_en <= 1'b0;
    endtask
    // rx clock runs for one symbol only; data flips afterwards so stale values never pass
    task automatic rx_sym(input logic [1:0] d);
        @(posedge core_clk) rmii_rxd <= d;
        repeat (3) @(posedge core_clk);
        rmii_rx_clk <= 1'b1;
        repeat (6) @(posedge core_clk);
        rmii_rx_clk <= 1'b0;
        rmii_rxd <= ~d;
    endtask
endmodule // pc2_mac_model

// *** testbench/pc2_monitor.sv ***
`timescale 1ns/1ps
module pc2_monitor (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        link_100,
    input wire logic        partner_forced_100,
    input wire logic        full_duplex,
    input wire logic        link_led,
    input wire logic        mii_isolate,
    input wire logic        rx_idle,
    input wire logic        rx_sym_err,
    input wire logic        rx_err_flag
);
    logic [15:0] sh_r;
    logic [15:0] sh_nxt;
    // shadow of control two, so checks track what software wrote
    always_comb begin
        sh_nxt = sh_r;
        // the register takes the write on the first access edge, the same edge on which pready rises
        if (psel && penable && !pready && pwrite && paddr == 12'h028) begin
            sh_nxt = pwdata[15:0] & pc2_pkg::PC2_CTRL2_WMASK;
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sh_r <= pc2_pkg::PC2_CTRL2_RST;
        end else begin
            sh_r <= sh_nxt;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    chk_rsvd_read: assert property (
        pready && !pwrite && paddr == 12'h028 |-> prdata[31:14] == 18'h0)
        else $error("reserved bits read nonzero");
    chk_unmapped_err: assert property (pready && !(paddr inside {12'h024, 12'h028, 12'h040})
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    chk_wait_state: assert property ($rose(psel && penable) |=> pready)
        else $error("no answer after one wait state");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    chk_idle_err: assert property (
        rx_err_flag == $past(rx_sym_err && (!rx_idle || sh_r[2])))
        else $error("idle symbol error flag wrong");
    chk_ext_duplex: assert property (
        $past(sh_r[5] && link_100 && partner_forced_100) |-> full_duplex)
        else $error("extended full duplex not applied");
    chk_led_qual: assert property (
        $past(sh_r[4] && !link_100) |-> !link_led) else $error("indicator lit on slow link");
    chk_iso_off: assert property (
        $past(!sh_r[3]) |-> !mii_isolate) else $error("isolated while disabled");
endmodule // pc2_monitor

// *** testbench/pc2_top_tb.sv ***
`timescale 1ns/1ps
module pc2_top_tb;
    localparam int PDN = 20;
    localparam int PDF = 5;
    logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pd_start = 0;
    logic link_up = 0, link_100 = 0, partner_forced_100 = 0, resolved_fd = 0;
    logic rx_idle = 0, rx_sym_err = 0, pready, pslverr, pd_done, full_duplex, link_led;
    logic mii_isolate, rx_err_flag, tx_nib_en, tx_nib_er, tx_en_out, tx_er_out, rmii_rx_clk;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0]  rmii_rxd, rmii_rxd_out;
    logic        perr;
    int          error_cnt = 0, compares = 0, cyc = 0;
    pc2_top #(.PD_NORMAL_CYC(PDN), .PD_FAST_CYC(PDF)) dut_u (.*);
    pc2_mac_model mac_u (.*);
    initial forever #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done;
        end
    end
    task automatic test_done;
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_regs;
        apb(0, 12'h028, 0);
        chk(rd, 32'h4);
        apb(0, 12'h024, 0);
        chk(rd, 32'h1);
        apb(1, 12'h028, 32'hffffffff);
        apb(0, 12'h028, 0);
        chk(rd, 32'h3fff);
        apb(1, 12'h0fc, 32'h1);
        apb(0, 12'h0fc, 0);
        chk({31'h0, perr}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_pd;
        int n[4];
        for (int k = 0; k < 4; k++) begin
            apb(1, 12'h028, k == 1 ? 32'h40 : 32'h0);
            apb(1, 12'h024, k == 2 ? 32'h40 : k == 3 ? 32'h20 : 32'h1);
            apb(0, 12'h028, 0);
            if (k > 1) chk(rd, 32'h40);
            @(posedge core_clk) pd_start <= 1'b1;
            @(posedge core_clk) pd_start <= 1'b0;
            n[k] = 0;
            while (pd_done !== 1'b1) begin
                @(posedge core_clk);
                n[k]++;
            end
        end
        // pd_done pulses length plus one cycles after the capture edge
        chk(n[0], PDN + 1);
        chk(n[1], PDF + 1);
        chk(n[2], PDF + 1);
        chk(n[3], PDF + 1);
        apb(1, 12'h024, 32'h1);
    endtask
    task automatic t_link;
        logic [5:0] b;
        logic       f;
        for (int i = 0; i < 64; i++) begin
            b = i[5:0];
            if (b[4:0] == 5'h0) apb(1, 12'h028, b[5] ? 32'h3c : 32'h0);
            @(posedge core_clk);
            {rx_idle, resolved_fd, partner_forced_100, link_100, link_up} <= b[4:0];
            rx_sym_err <= b[0] ^ b[2];
            repeat (2) @(posedge core_clk);
            f = b[3] | (b[5] & b[1] & b[2]);
            chk({full_duplex, link_led, mii_isolate, rx_err_flag},
                {f, b[5] ? b[0] & b[1] & f : b[0], b[5] & b[0] & b[1] & !f,
                 (b[0] ^ b[2]) & (!b[4] | b[5])});
        end
    endtask
    task automatic t_tx;
        int n, en, er;
        for (int k = 0; k < 3; k++) begin
            apb(1, 12'h028, k == 1 ? 32'h2 : 32'h0);
            n = k == 2 ? 4 : 3;
            en = 0;
            er = 0;
            fork
                mac_u.send(n);
                repeat (n + 5) @(posedge core_clk) begin
                    en += tx_en_out;
                    er += tx_er_out;
                end
            join
            chk(en, n + (k == 0));
            chk(er, int'(k == 0));
        end
    endtask
    task automatic t_rmii;
        for (int k = 0; k < 2; k++) begin
            apb(1, 12'h028, k);
            mac_u.rx_sym(2'h1);
            repeat (2) @(posedge core_clk);
            chk(rmii_rxd_out, k ? 2'h1 : 2'h2);
        end
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        t_regs;
        t_pd;
        t_link;
        t_tx;
        t_rmii;
        test_done;
    end
endmodule // pc2_top_tb
bind pc2_top pc2_monitor mon_u (.*);
